// ---- logic/rbm_consts.svh ----
// Constants for the reset, boot and memory-map decoder.
// Assumes inclusion by rbm_pkg and the design modules only.
`ifndef RBM_CONSTS_SVH
`define RBM_CONSTS_SVH
`define RBM_STRAP_CYCLES        10
`define RBM_INT_MEM_TOP         32'h0040_0000
`define RBM_PERIPH_BASE         32'hffc0_0000
`define RBM_BANK_SHIFT          24
`define RBM_RAM_BYTES           8192
`define RBM_RAM_WORDS           2048
`define RBM_RAM_AW              11
`define RBM_NUM_BANKS           8
`define RBM_WAIT_W              3
`define RBM_FLOAT_W             3
`endif

// ---- logic/rbm_pkg.sv ----
// Types for the reset, boot and memory-map decoder.
// Assumes the constants header sits beside it.
`include "rbm_consts.svh"
package rbm_pkg;
	typedef enum logic [1:0] {
		RBM_REG_INTMEM = 2'b00,
		RBM_REG_EXT    = 2'b01,
		RBM_REG_PERIPH = 2'b10
	} rbm_region_e;
	typedef enum logic [1:0] {
		RBM_SZ_BYTE = 2'b00,
		RBM_SZ_HALF = 2'b01,
		RBM_SZ_WORD = 2'b10
	} rbm_size_e;
	typedef enum logic [1:0] {
		RBM_ST_RESET = 2'b00,
		RBM_ST_RUN   = 2'b01
	} rbm_state_e;
endpackage : rbm_pkg

// ---- logic/rbm_ram.sv ----
// Internal 8-Kbyte single-cycle RAM, little-endian byte lanes.
// Assumes byte enables already aligned by the decoder.
`timescale 1ns/10ps
`include "rbm_consts.svh"
module rbm_ram #(
	parameter int AW = `RBM_RAM_AW
) (
	input  wire logic          i_clk,   // Master clock
	input  wire logic          i_en,    // Access strobe
	input  wire logic          i_we,    // Write
	input  wire logic [AW-1:0] i_addr,  // Word index
	input  wire logic [3:0]    i_be,    // Byte enables
	input  wire logic [31:0]   i_wdata, // Write data
	output logic      [31:0]   o_rdata  // Read data
);
	logic [31:0] mem [0:(1<<AW)-1];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			always_ff @(posedge i_clk) begin
				if (i_en && i_we && i_be[g]) begin
					mem[i_addr][8*g +: 8] <= i_wdata[8*g +: 8];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_en) begin
			o_rdata <= mem[i_addr];
		end
	end
endmodule : rbm_ram

// ---- logic/rbm_top.sv ----
// Reset sequencing, strap capture, debug select and address decode.
// Assumes the core presents one access per cycle, answered next cycle.
`timescale 1ns/10ps
`include "rbm_consts.svh"
// Overview of operation
// - Reset asserts async, releases on master clock
// - Reset defaults registers, fetch from zero
// - Test reset hits only selected controller
// - Select low emulation, high boundary scan
// - Scan: SAMPLE, EXTEST, BYPASS, no identity
// - Watchdog reset keeps previous strap modes
// - Hardware reset beats watchdog reset
// - Tri-state if request low last ten
// - Tri-state disables every output driver
// - Boot width sampled last ten cycles
// - Address space split three ways
// - Little-endian byte ordering only
// - RAM at zero after remap, single-cycle
// - Remap one swaps; only reset undoes
// - Abort on undefined external address
// - No abort internal reads or peripherals
// - External unit serves eight 16-Mbyte banks
// - Each bank has own programmable settings
// - Peripheral pins inputs while in reset
// - Writing zero to command bit ignored
module rbm_top
	import rbm_pkg::*;
#(
	parameter int          NUM_BANKS = `RBM_NUM_BANKS,
	parameter logic [7:0]  BANK_DEFINED = 8'hff
) (
	input  wire logic                  i_clk,               // Master clock
	input  wire logic                  i_rst_b,             // Hardware reset pin, low active
	input  wire logic                  i_wd_reset,          // Watchdog reset pulse
	input  wire logic                  i_test_reset_n,      // Test reset pin, low active
	input  wire logic                  i_debug_port_select, // Low emulation, high scan
	input  wire logic                  i_tristate_request_n,// Tri-state strap, low active
	input  wire logic                  i_boot_width_select, // 1: 8-bit boot, 0: 16-bit
	input  wire logic                  i_remap_command_bit, // Remap command write strobe data
	input  wire logic                  i_remap_wr,          // Remap control register write
	input  wire logic [NUM_BANKS-1:0]  i_bank_enable,       // Bank programmed
	input  wire logic [NUM_BANKS*`RBM_WAIT_W-1:0]  i_bank_wait,  // Wait states per bank
	input  wire logic [NUM_BANKS*`RBM_FLOAT_W-1:0] i_bank_float, // Float time per bank
	input  wire logic [NUM_BANKS-1:0]  i_bank_wide,         // 1: 16-bit bank
	input  wire logic [NUM_BANKS-1:0]  i_bank_bytewrite,    // 1: byte-write mode
	input  wire logic                  i_req,               // Core access request
	input  wire logic                  i_we,                // Write
	input  wire logic                  i_fetch,             // Instruction fetch
	input  wire logic [31:0]           i_addr,              // Byte address
	input  wire rbm_pkg::rbm_size_e    i_size,              // Access size
	input  wire logic [31:0]           i_wdata,             // Write data
	output logic                       o_sys_rst_n,         // Internal system reset, low active
	output logic                       o_ice_tap_rst_n,     // Emulation TAP reset, low active
	output logic                       o_scan_tap_rst_n,    // Scan TAP reset, low active
	output logic                       o_ice_enable,        // Emulation debug enabled
	output logic                       o_scan_enable,       // Boundary scan enabled
	output logic                       o_scan_idcode_en,    // Scan identity register present
	output logic                       o_tristate_mode,     // All outputs disabled
	output logic                       o_pad_oe_allow,      // Output driver permit
	output logic                       o_pio_outputs_en,    // Peripheral pins may drive
	output logic                       o_boot_8bit,         // Boot width captured
	output logic                       o_remapped,          // Remap done
	output logic                       o_ram_sel,           // Access goes to RAM
	output logic                       o_ext_sel,           // Access goes external
	output logic                       o_periph_sel,        // Access goes to peripherals
	output logic [2:0]                 o_ext_bank,          // External bank index
	output logic [3:0]                 o_ext_wait,          // Selected wait states
	output logic [3:0]                 o_ext_float,         // Selected float time
	output logic                       o_ext_wide,          // Selected 16-bit width
	output logic                       o_ext_bytewrite,     // Selected byte-write mode
	output logic                       o_abort,             // Data abort
	output logic                       o_prefetch_abort,    // Prefetch abort
	output logic [31:0]                o_rdata,             // RAM read data
	output logic                       o_fetch_zero         // First fetch after reset from zero
);
	import rbm_pkg::*;

	// Pin synchronisers
	logic [1:0] rst_sync_reg;
	logic [1:0] tri_sync_reg;
	logic [1:0] bms_sync_reg;
	logic [1:0] sel_sync_reg;
	logic [1:0] trst_sync_reg;
	logic       rst_hold_reg;

	// Third stage: strap capture and reset exit share one edge
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_sync_reg <= 2'h0;
			rst_hold_reg <= 1'b0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
			rst_hold_reg <= rst_sync_reg[1];
		end
	end

	always_ff @(posedge i_clk) begin
		tri_sync_reg  <= {tri_sync_reg[0], i_tristate_request_n};
		bms_sync_reg  <= {bms_sync_reg[0], i_boot_width_select};
		sel_sync_reg  <= {sel_sync_reg[0], i_debug_port_select};
		trst_sync_reg <= {trst_sync_reg[0], i_test_reset_n};
	end

	wire hw_in_reset = ~rst_hold_reg;
	// Hardware reset outranks watchdog; watchdog adds no strap capture
	wire sys_reset   = hw_in_reset | i_wd_reset;

	// Strap windows: consecutive low/high counts while pin reset is held
	logic [3:0] tri_low_cnt_reg;
	logic [3:0] bms_hi_cnt_reg;
	logic [3:0] bms_lo_cnt_reg;
	logic       tristate_reg;
	logic       boot_8bit_reg;
	logic       debug_sel_reg;
	logic       remap_reg;
	logic       fetch_zero_reg;

	wire [3:0] strap_full = 4'(`RBM_STRAP_CYCLES);
	wire [3:0] tri_low_cnt_next = !tri_sync_reg[1] ?
		((tri_low_cnt_reg == strap_full) ? strap_full : tri_low_cnt_reg + 4'h1) : 4'h0;
	wire [3:0] bms_hi_cnt_next = bms_sync_reg[1] ?
		((bms_hi_cnt_reg == strap_full) ? strap_full : bms_hi_cnt_reg + 4'h1) : 4'h0;
	wire [3:0] bms_lo_cnt_next = !bms_sync_reg[1] ?
		((bms_lo_cnt_reg == strap_full) ? strap_full : bms_lo_cnt_reg + 4'h1) : 4'h0;
	// Release edge: the cycle hardware reset leaves
	wire release_now = hw_in_reset & rst_sync_reg[1];

	always_ff @(posedge i_clk) begin
		if (hw_in_reset) begin
			tri_low_cnt_reg <= tri_low_cnt_next;
			bms_hi_cnt_reg  <= bms_hi_cnt_next;
			bms_lo_cnt_reg  <= bms_lo_cnt_next;
		end
	end

	// Straps caught at release only; watchdog reset leaves them alone
	always_ff @(posedge i_clk) begin
		if (release_now) begin
			tristate_reg  <= (tri_low_cnt_next == strap_full);
			// Unstable width strap falls back to 8-bit, the safer guess
			boot_8bit_reg <= (bms_hi_cnt_next == strap_full) | (bms_lo_cnt_next != strap_full);
			debug_sel_reg <= sel_sync_reg[1];
		end
	end

	// Remap: set by written one, cleared only by a reset
	wire remap_set = i_remap_wr & i_remap_command_bit;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			remap_reg      <= 1'b0;
			fetch_zero_reg <= 1'b1;
		end else if (i_wd_reset) begin
			remap_reg      <= 1'b0;
			fetch_zero_reg <= 1'b1;
		end else begin
			remap_reg      <= remap_reg | remap_set;
			fetch_zero_reg <= fetch_zero_reg & ~(i_req & i_fetch & ~hw_in_reset);
		end
	end

	// Outputs of reset and debug selection
	assign o_sys_rst_n      = ~sys_reset;
	assign o_ice_enable     = ~debug_sel_reg;
	assign o_scan_enable    = debug_sel_reg;
	assign o_scan_idcode_en = 1'b0;
	assign o_ice_tap_rst_n  = ~(~trst_sync_reg[1] & ~debug_sel_reg);
	assign o_scan_tap_rst_n = ~(~trst_sync_reg[1] & debug_sel_reg);
	assign o_tristate_mode  = tristate_reg;
	assign o_pad_oe_allow   = ~tristate_reg & ~sys_reset;
	assign o_pio_outputs_en = ~sys_reset & ~tristate_reg;
	assign o_boot_8bit      = boot_8bit_reg;
	assign o_remapped       = remap_reg;
	assign o_fetch_zero     = fetch_zero_reg;

	// Address decode
	wire in_low    = i_addr < `RBM_INT_MEM_TOP;
	wire in_periph = i_addr >= `RBM_PERIPH_BASE;
	wire in_ext    = ~in_low & ~in_periph;
	wire [2:0] bank_idx = i_addr[`RBM_BANK_SHIFT +: 3];
	// Before remap the low region is boot flash on chip select zero
	wire low_is_ram = remap_reg;
	wire ram_hit    = in_low & low_is_ram & (i_addr < 32'(`RBM_RAM_BYTES));
	wire boot_hit   = in_low & ~low_is_ram;
	wire [2:0] sel_bank = boot_hit ? 3'h0 : bank_idx;
	// Chip selects above zero are undefined until remapped
	wire bank_ok    = BANK_DEFINED[sel_bank] & i_bank_enable[sel_bank] & (remap_reg | sel_bank == 3'h0);
	wire misalign   = (i_size == RBM_SZ_HALF & i_addr[0]) | (i_size == RBM_SZ_WORD & |i_addr[1:0]);
	wire ext_go     = i_req & ~sys_reset & (in_ext | boot_hit);
	wire undef_ext  = ext_go & (~bank_ok | misalign);
	// Little-endian lane enables, the only byte order offered
	wire [3:0] lane_be = (i_size == RBM_SZ_BYTE) ? (4'h1 << i_addr[1:0]) :
		(i_size == RBM_SZ_HALF) ? (i_addr[1] ? 4'hc : 4'h3) : 4'hf;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ram_sel        <= 1'b0;
			o_ext_sel        <= 1'b0;
			o_periph_sel     <= 1'b0;
			o_ext_bank       <= 3'h0;
			o_ext_wait       <= 4'h0;
			o_ext_float      <= 4'h0;
			o_ext_wide       <= 1'b0;
			o_ext_bytewrite  <= 1'b0;
			o_abort          <= 1'b0;
			o_prefetch_abort <= 1'b0;
		end else begin
			o_ram_sel        <= i_req & ~sys_reset & ram_hit;
			o_ext_sel        <= ext_go & ~undef_ext;
			o_periph_sel     <= i_req & ~sys_reset & in_periph;
			o_ext_bank       <= sel_bank;
			o_ext_wait       <= 4'(i_bank_wait[sel_bank*`RBM_WAIT_W +: `RBM_WAIT_W]);
			o_ext_float      <= 4'(i_bank_float[sel_bank*`RBM_FLOAT_W +: `RBM_FLOAT_W]);
			// Boot bank width comes from the strap, not the bank setting
			o_ext_wide       <= boot_hit ? ~boot_8bit_reg : i_bank_wide[sel_bank];
			o_ext_bytewrite  <= i_bank_wide[sel_bank] & i_bank_bytewrite[sel_bank];
			o_abort          <= undef_ext & ~i_fetch;
			o_prefetch_abort <= undef_ext & i_fetch;
		end
	end

	rbm_ram #(
		.AW (`RBM_RAM_AW)
	) u_ram (
		.i_clk   (i_clk),
		.i_en    (i_req & ram_hit & ~sys_reset),
		.i_we    (i_we),
		.i_addr  (i_addr[`RBM_RAM_AW+1:2]),
		.i_be    (lane_be),
		.i_wdata (i_wdata),
		.o_rdata (o_rdata)
	);

	chk_remap_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(remap_reg & ~i_wd_reset) |=> remap_reg) else $error("remap dropped");
	chk_zero_no_remap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_remap_wr & ~i_remap_command_bit & ~remap_reg & ~i_wd_reset) |=> ~remap_reg) else $error("zero remapped");
	chk_no_periph_abort: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_req & (in_periph | in_low & remap_reg)) |=> ~o_abort & ~o_prefetch_abort) else $error("internal abort");
	chk_ext_abort: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_req & ~sys_reset & in_ext & ~i_fetch & (~BANK_DEFINED[bank_idx] | ~i_bank_enable[bank_idx])) |=> o_abort)
		else $error("missing abort");
	chk_tri_oe_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_tristate_mode |-> ~o_pad_oe_allow & ~o_pio_outputs_en) else $error("driver on in tristate");
	chk_wd_keeps_strap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_wd_reset & ~hw_in_reset) |=> $stable(boot_8bit_reg) & $stable(tristate_reg)) else $error("strap changed");
	chk_tap_select: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_scan_enable |-> o_ice_tap_rst_n & ~o_ice_enable) else $error("wrong tap reset");
	chk_no_idcode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_scan_enable |-> ~o_scan_idcode_en) else $error("idcode present");
	chk_sync_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$rose(rst_sync_reg[1]) |-> $past(rst_sync_reg[0])) else $error("async release");
	chk_boot_width: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_req & ~sys_reset & boot_hit & ~undef_ext) |=> o_ext_wide == ~o_boot_8bit) else $error("boot width");
endmodule : rbm_top

// ---- testbench/rbm_core_model.sv ----
// Core-side model: issues one access at a time on the decoder's request port.
// Assumes the answer is sampled by the caller 1 ns after the taking edge.
`timescale 1ns/10ps
module rbm_core_model
	import rbm_pkg::*;
(
	input  wire logic                i_clk,   // Master clock
	output logic                     o_req,   // Access request
	output logic                     o_we,    // Write
	output logic                     o_fetch, // Instruction fetch
	output logic [31:0]              o_addr,  // Byte address
	output rbm_pkg::rbm_size_e       o_size,  // Access size
	output logic [31:0]              o_wdata  // Write data
);
	import rbm_pkg::*;
	initial begin
		o_req = 1'b0;
		o_we = 1'b0;
		o_fetch = 1'b0;
		o_addr = 32'h0000_0000;
		o_size = RBM_SZ_WORD;
		o_wdata = 32'h0000_0000;
	end
	// Held for exactly one taking edge; answer stands in the following cycle
	task automatic access(input logic we, input logic fe, input logic [31:0] a, input rbm_size_e sz,
		input logic [31:0] d);
		@(posedge i_clk);
		o_req <= 1'b1;
		o_we <= we;
		o_fetch <= fe;
		o_addr <= a;
		o_size <= sz;
		o_wdata <= d;
		@(posedge i_clk);
		o_req <= 1'b0;
		o_we <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		#1;
	endtask : access
endmodule : rbm_core_model

// ---- testbench/tb_rbm_top.sv ----
// Self-checking bench for the reset, boot and memory-map decoder.
// Assumes the core model drives the access port and straps are plain inputs.
`timescale 1ns/10ps
module tb_rbm_top;
	import rbm_pkg::*;
	logic i_clk = 1'b0, i_rst_b = 1'b0, wd = 1'b0, trst_n = 1'b1, dsel = 1'b0, tri_n = 1'b1, bw = 1'b0;
	logic remap_command_bit = 1'b0, rwr = 1'b0, req, we, fe;
	logic [7:0] ben = 8'hdf, wide = 8'haa, bwr = 8'h0c;
	logic [23:0] bwait, bflt;
	logic [31:0] addr, wdata, rdata;
	rbm_size_e sz;
	logic srst_n, ice_rst_n, scan_rst_n, ice_en, scan_en, idc, trim, oe_ok, pio_en, b8, remap;
	logic ram_s, ext_s, per_s, e_wide, e_bw, abt, pabt, fzero;
	logic [2:0] bank;
	logic [3:0] e_wait, e_flt;
	int err_count = 0, checks = 0, cyc = 0;
	always #20 i_clk = ~i_clk;
	initial for (int n = 0; n < 8; n++) begin
		bwait[3*n+:3] = 3'(n);
		bflt[3*n+:3] = 3'(7 - n);
	end
	rbm_core_model core (.i_clk(i_clk), .o_req(req), .o_we(we), .o_fetch(fe), .o_addr(addr), .o_size(sz),
		.o_wdata(wdata));
	rbm_top uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wd_reset(wd), .i_test_reset_n(trst_n),
		.i_debug_port_select(dsel), .i_tristate_request_n(tri_n), .i_boot_width_select(bw),
		.i_remap_command_bit(remap_command_bit), .i_remap_wr(rwr), .i_bank_enable(ben), .i_bank_wait(bwait),
		.i_bank_float(bflt), .i_bank_wide(wide), .i_bank_bytewrite(bwr), .i_req(req), .i_we(we),
		.i_fetch(fe), .i_addr(addr), .i_size(sz), .i_wdata(wdata), .o_sys_rst_n(srst_n),
		.o_ice_tap_rst_n(ice_rst_n), .o_scan_tap_rst_n(scan_rst_n), .o_ice_enable(ice_en),
		.o_scan_enable(scan_en), .o_scan_idcode_en(idc), .o_tristate_mode(trim), .o_pad_oe_allow(oe_ok),
		.o_pio_outputs_en(pio_en), .o_boot_8bit(b8), .o_remapped(remap), .o_ram_sel(ram_s),
		.o_ext_sel(ext_s), .o_periph_sel(per_s), .o_ext_bank(bank), .o_ext_wait(e_wait),
		.o_ext_float(e_flt), .o_ext_wide(e_wide), .o_ext_bytewrite(e_bw), .o_abort(abt),
		.o_prefetch_abort(pabt), .o_rdata(rdata), .o_fetch_zero(fzero));
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Reset held 14 cycles so the strap window fills through the synchroniser
	task automatic hw_reset(input logic t, input logic b, input logic d, input logic w);
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		tri_n <= t;
		bw <= b;
		dsel <= d;
		wd <= w;
		#1 chk(srst_n, 1'b0);
		repeat (14) @(posedge i_clk);
		i_rst_b <= 1'b1;
		wd <= 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
	endtask : hw_reset
	task automatic remap_wr(input logic bit_v);
		@(posedge i_clk);
		remap_command_bit <= bit_v;
		rwr <= 1'b1;
		@(posedge i_clk);
		rwr <= 1'b0;
		remap_command_bit <= 1'b0;
		#1;
	endtask : remap_wr
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_b <= 1'b1;
		hw_reset(1'b0, 1'b1, 1'b1, 1'b0);
		chk({trim, oe_ok, pio_en, b8}, 4'b1001);
		chk({scan_en, ice_en, idc}, 3'b100);
		@(posedge i_clk);
		trst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1 chk({ice_rst_n, scan_rst_n}, 2'b10);
		@(posedge i_clk);
		trst_n <= 1'b1;
		$display("Test straps and scan port done");
		hw_reset(1'b1, 1'b0, 1'b0, 1'b1);
		chk({trim, oe_ok, pio_en, b8, fzero, remap}, 6'b011010);
		chk({ice_en, scan_en}, 2'b10);
		@(posedge i_clk);
		trst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1 chk({ice_rst_n, scan_rst_n}, 2'b01);
		@(posedge i_clk);
		trst_n <= 1'b1;
		core.access(1'b0, 1'b1, 32'h0000_0000, RBM_SZ_WORD, 32'h0);
		chk({ram_s, ext_s, bank, e_wide, abt, pabt}, 8'b01000100);
		chk(fzero, 1'b0);
		core.access(1'b0, 1'b0, 32'h0100_0000, RBM_SZ_WORD, 32'h0);
		chk({abt, pabt}, 2'b10);
		remap_wr(1'b0);
		chk(remap, 1'b0);
		remap_wr(1'b1);
		chk(remap, 1'b1);
		$display("Test boot map and remap done");
		core.access(1'b1, 1'b0, 32'h0000_0010, RBM_SZ_WORD, 32'h4433_2211);
		core.access(1'b1, 1'b0, 32'h0000_0011, RBM_SZ_BYTE, 32'h0000_ab00);
		core.access(1'b1, 1'b0, 32'h0000_0012, RBM_SZ_HALF, 32'hcdef_0000);
		core.access(1'b0, 1'b0, 32'h0000_0010, RBM_SZ_WORD, 32'h0);
		chk({ram_s, abt}, 2'b10);
		chk(rdata, 32'hcdef_ab11);
		core.access(1'b0, 1'b0, 32'h0030_0000, RBM_SZ_WORD, 32'h0);
		chk({ram_s, abt, pabt}, 3'b000);
		core.access(1'b1, 1'b0, 32'hffc0_0003, RBM_SZ_BYTE, 32'h0);
		chk({per_s, abt, pabt}, 3'b100);
		$display("Test internal regions done");
		for (int n = 1; n < 8; n++) begin
			core.access(1'b0, 1'b0, (32'(n) << 24) + 32'h4, RBM_SZ_WORD, 32'h0);
			chk({abt, pabt}, (n == 5) ? 2'b10 : 2'b00);
			if (n != 5) begin
				chk({ext_s, bank, e_wait, e_flt, e_wide, e_bw},
					{1'b1, 3'(n), 4'(n), 4'(7 - n), wide[n], wide[n] & bwr[n]});
			end
		end
		core.access(1'b0, 1'b1, 32'h0500_0000, RBM_SZ_WORD, 32'h0);
		chk({abt, pabt}, 2'b01);
		core.access(1'b0, 1'b0, 32'h0300_0001, RBM_SZ_WORD, 32'h0);
		chk({abt, pabt}, 2'b10);
		$display("Test external banks done");
		@(posedge i_clk);
		wd <= 1'b1;
		tri_n <= 1'b0;
		bw <= 1'b1;
		repeat (14) @(posedge i_clk);
		#1 chk(srst_n, 1'b0);
		@(posedge i_clk);
		wd <= 1'b0;
		repeat (4) @(posedge i_clk);
		#1 chk({remap, trim, b8, fzero}, 4'b0001);
		$display("Test watchdog reset done");
		stop_test();
	end
endmodule : tb_rbm_top
